// [ext_io.sv]
// External control connector logic of an electronic load: range select,
// range and load status, alarm input, short contact, trigger pulse.
// Assumes an APB master on pclk; pins are asynchronous and pulled up.
// Notes on behaviour
// RULE_01: Load state output active while load on, inactive while off.
// RULE_02: Range select pins honoured only with source V, R or RIV.
// RULE_03: External range selection only when manual range is high.
// RULE_04: Pins 11 high, 10 middle, 01 low.
// RULE_05: Status pins: 00 high, bit0 on middle, bit1 on low.
// RULE_06: Alarm active while alarm pin low; open pin reads high.
// RULE_07: Active alarm also raises the external alarm message.
// RULE_08: Outside party pulls alarm pin low, releases high to clear.
// RULE_09: Short contact open when short inactive, closed while active.
// RULE_10: One trigger pulse per dynamic-mode level switch; a switch during a running pulse restarts it and adds no pulse.
// RULE_11: Sequence steps pulse trigger only when sequence trigger enabled.
// RULE_12: Trigger pulse high for at least the minimum width.
// RULE_13: Monitor scale large for high and low, small for middle.
// RULE_14: Range select and alarm pins synchronised before decoding.
// RULE_15: Both select pins low keeps the active range.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module ext_io
  import ext_io_pkg::*;
#(
  parameter int unsigned TRIG_LEN = TRIG_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        range_sel1,
  input  wire logic        range_sel0,
  input  wire logic        alarm_in_n,
  output logic             load_on_status,
  output logic             range_status1,
  output logic             range_status0,
  output logic             short_contact,
  output logic             trigger_pulse_output,
  output logic             current_monitor_output,
  output logic             alarm_active,
  output logic             external_alarm_message
);

  typedef struct packed {
    logic                  load_on;
    logic                  short_on;
    logic                  seq_trig_en;
    src_type               src;
    range_type             manual;
    range_type             active;
    logic                  msg;
    logic [TRIG_CNT_W-1:0] trig_cnt;
    logic [31:0]           rdata;
  } state_type;

  state_type st_q;
  state_type st_d;

  logic sel1_s;
  logic sel0_s;
  logic alarm_n_s;
  logic ext_ok;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic fire;

  // Every assertion below lives on pclk and sleeps through reset
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Pin synchronisers [RULE_14]
  pin_sync u_sel1 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (range_sel1),
    .level   (sel1_s)
  );
  pin_sync u_sel0 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (range_sel0),
    .level   (sel0_s)
  );
  pin_sync u_alarm (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (alarm_in_n),
    .level   (alarm_n_s)
  );

  // APB decode; zero wait states
  assign addr_ok = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) ||
                   (paddr == EVENT_ADDR);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // External selection needs a V/R/RIV source and manual high range
  assign ext_ok = ((st_q.src == SRC_V) || (st_q.src == SRC_R) ||   // [RULE_02]
                   (st_q.src == SRC_RIV)) &&
                  (st_q.manual == RANGE_HIGH);                      // [RULE_03]

  // Trigger request from a dynamic switch or an enabled sequence step
  assign fire = wr_en && (paddr == EVENT_ADDR) &&
                (pwdata[EV_DYN_BIT] ||                              // [RULE_10]
                 (pwdata[EV_SEQ_BIT] && st_q.seq_trig_en));         // [RULE_11]

  // Next-state logic
  always_comb begin
    st_d = st_q;
    if (wr_en && (paddr == CTRL_ADDR)) begin
      st_d.load_on     = pwdata[CTRL_LOAD_BIT];
      st_d.short_on    = pwdata[CTRL_SHORT_BIT];
      st_d.seq_trig_en = pwdata[CTRL_SEQTRG_BIT];
      st_d.src         = src_type'(pwdata[CTRL_SRC_LSB +: 3]);
      st_d.manual      = range_type'(pwdata[CTRL_RANGE_LSB +: 2]);
    end
    // Active range follows pins when allowed, else the manual setting
    if (ext_ok) begin
      case ({sel1_s, sel0_s})                                      // [RULE_04]
        SEL_HIGH: st_d.active = RANGE_HIGH;
        SEL_MID:  st_d.active = RANGE_MID;
        SEL_LOW:  st_d.active = RANGE_LOW;
        default:  st_d.active = st_q.active;                       // [RULE_15]
      endcase
    end else begin
      st_d.active = st_q.manual;
    end
    // Message is sticky; the alarm sets it and wins over a clear
    if (wr_en && (paddr == EVENT_ADDR) && pwdata[EV_MSGCLR_BIT]) begin
      st_d.msg = 1'b0;
    end
    if (!alarm_n_s) begin
      st_d.msg = 1'b1;                                             // [RULE_07]
    end
    // Stretcher restarts on each request so back-to-back pulses merge
    if (fire) begin
      st_d.trig_cnt = TRIG_CNT_W'(TRIG_LEN);                       // [RULE_12]
    end else if (st_q.trig_cnt != '0) begin
      st_d.trig_cnt = st_q.trig_cnt - 1'b1;
    end
    // Read data captured in setup phase
    st_d.rdata = RESET_WORD;
    if (rd_en) begin
      case (paddr)
        CTRL_ADDR: begin
          st_d.rdata[CTRL_LOAD_BIT]         = st_q.load_on;
          st_d.rdata[CTRL_SHORT_BIT]        = st_q.short_on;
          st_d.rdata[CTRL_SEQTRG_BIT]       = st_q.seq_trig_en;
          st_d.rdata[CTRL_SRC_LSB +: 3]     = st_q.src;
          st_d.rdata[CTRL_RANGE_LSB +: 2]   = st_q.manual;
        end
        STATUS_ADDR: begin
          st_d.rdata[ST_RANGE_LSB +: 2] = st_q.active;
          st_d.rdata[ST_ALARM_BIT]      = !alarm_n_s;
          st_d.rdata[ST_MSG_BIT]        = st_q.msg;
          st_d.rdata[ST_SHORT_BIT]      = st_q.short_on;
          st_d.rdata[ST_LOAD_BIT]       = st_q.load_on;
          st_d.rdata[ST_TRIG_BIT]       = (st_q.trig_cnt != '0);
          st_d.rdata[ST_SCALE_BIT]      = (st_q.active != RANGE_MID);
          st_d.rdata[ST_EXTOK_BIT]      = ext_ok;
        end
        default: st_d.rdata = RESET_WORD;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign prdata                 = st_q.rdata;
  assign load_on_status         = st_q.load_on;                    // [RULE_01]
  assign short_contact          = st_q.short_on;                   // [RULE_09]
  assign trigger_pulse_output   = (st_q.trig_cnt != '0);           // [RULE_12]
  assign current_monitor_output = (st_q.active != RANGE_MID);      // [RULE_13]
  assign alarm_active           = !alarm_n_s;                      // [RULE_06]
  assign external_alarm_message = st_q.msg;

  // Range status pins [RULE_05]
  always_comb begin
    case (st_q.active)
      RANGE_MID: {range_status1, range_status0} = RST_MID;
      RANGE_LOW: {range_status1, range_status0} = RST_LOW;
      default:   {range_status1, range_status0} = RST_HIGH;
    endcase
  end

  // Assertions; stretcher length copied to an int for the casts
  int unsigned trig_len_c;
  assign trig_len_c = TRIG_LEN;

  // Trigger: loaded on request, held for at least two cycles, ends only from one
  trig_width_a: assert property ( // [RULE_12]
    fire |=> trigger_pulse_output [*2])
    else $error("trigger pulse too short");
  trig_len_a: assert property ( // [RULE_12]
    fire |=> (st_q.trig_cnt == TRIG_CNT_W'(trig_len_c)))
    else $error("trigger stretcher not loaded");
  trig_end_a: assert property ( // [RULE_12]
    $fell(trigger_pulse_output) |->
      ($past(st_q.trig_cnt) == TRIG_CNT_W'(1)))
    else $error("trigger pulse cut short");
  dyn_pulse_a: assert property ( // [RULE_10]
    (wr_en && paddr == EVENT_ADDR && pwdata[EV_DYN_BIT]) |=>
      trigger_pulse_output)
    else $error("dynamic switch gave no pulse");
  seq_fire_a: assert property ( // [RULE_11]
    (wr_en && paddr == EVENT_ADDR && pwdata[EV_SEQ_BIT] &&
     st_q.seq_trig_en) |=> trigger_pulse_output)
    else $error("enabled sequence step gave no pulse");
  seq_gate_a: assert property ( // [RULE_11]
    (wr_en && paddr == EVENT_ADDR && !pwdata[EV_DYN_BIT] &&
     !st_q.seq_trig_en && !trigger_pulse_output) |=> !trigger_pulse_output)
    else $error("sequence trigger while disabled");

  // Alarm and sticky message; a clear only lands once the pin is idle
  alarm_msg_a: assert property ( // [RULE_07]
    alarm_active |=> external_alarm_message)
    else $error("alarm message not raised");
  msg_hold_a: assert property ( // [RULE_07]
    (external_alarm_message &&
     !(wr_en && paddr == EVENT_ADDR && pwdata[EV_MSGCLR_BIT])) |=>
      external_alarm_message)
    else $error("alarm message lost without a clear");
  msg_clear_a: assert property ( // [RULE_07]
    (wr_en && paddr == EVENT_ADDR && pwdata[EV_MSGCLR_BIT] && alarm_n_s)
      |=> !external_alarm_message)
    else $error("alarm message not cleared");
  alarm_lvl_a: assert property ( // [RULE_06]
    alarm_active == !alarm_n_s)
    else $error("alarm level mismatch");

  // Range selection; active lags the setting by one cycle
  range_ign_a: assert property ( // [RULE_03]
    (st_q.manual != RANGE_HIGH && $stable(st_q.manual))
      |=> st_q.active == $past(st_q.manual))
    else $error("range pins not ignored");
  src_gate_a: assert property ( // [RULE_02]
    (st_q.src == SRC_OFF) |=> st_q.active == $past(st_q.manual))
    else $error("range pins honoured without a source");
  range_hold_a: assert property ( // [RULE_15]
    (ext_ok && !sel1_s && !sel0_s) |=> $stable(st_q.active))
    else $error("range changed on 00 select");
  range_high_a: assert property ( // [RULE_04]
    (ext_ok && sel1_s && sel0_s) |=> (!range_status0 && !range_status1))
    else $error("high range not shown");
  range_mid_a: assert property ( // [RULE_04]
    (ext_ok && sel1_s && !sel0_s) |=> (range_status0 && !range_status1))
    else $error("middle range not shown");
  range_low_a: assert property ( // [RULE_04]
    (ext_ok && !sel1_s && sel0_s) |=> (!range_status0 && range_status1))
    else $error("low range not shown");

  // Status pin pairs, written out independently of the package codes
  stat_high_a: assert property ( // [RULE_05]
    (st_q.active == RANGE_HIGH) |-> (!range_status1 && !range_status0))
    else $error("high range status wrong");
  stat_mid_a: assert property ( // [RULE_05]
    (st_q.active == RANGE_MID) |-> (!range_status1 && range_status0))
    else $error("middle range status wrong");
  stat_low_a: assert property ( // [RULE_05]
    (st_q.active == RANGE_LOW) |-> (range_status1 && !range_status0))
    else $error("low range status wrong");
  scale_sel_a: assert property ( // [RULE_13]
    current_monitor_output == !(range_status0 && !range_status1))
    else $error("monitor scale wrong");

  // Load and short follow the control word and read back in status
  load_stat_a: assert property ( // [RULE_01]
    (wr_en && paddr == CTRL_ADDR) |=>
      load_on_status == $past(pwdata[CTRL_LOAD_BIT]))
    else $error("load status not updated");
  short_stat_a: assert property ( // [RULE_09]
    (wr_en && paddr == CTRL_ADDR) |=>
      short_contact == $past(pwdata[CTRL_SHORT_BIT]))
    else $error("short contact not updated");
  rd_status_a: assert property ( // [RULE_01]
    (rd_en && paddr == STATUS_ADDR) |=>
      prdata[ST_LOAD_BIT] == $past(load_on_status))
    else $error("status read lost load state");

  // Main scenarios
  ext_range_c: cover property (ext_ok && st_q.active == RANGE_LOW);
  trig_fire_c: cover property (fire);
  alarm_seen_c: cover property (alarm_active ##1 !alarm_active);
  range_hold_c: cover property (ext_ok && !sel1_s && !sel0_s);
  msg_clear_c: cover property (
    external_alarm_message ##1 !external_alarm_message);
endmodule

// [ext_io_pkg.sv]
// Constants, register map and encodings for the external control I/O block.
// Assumes a 25 MHz pclk and an APB master with 32-bit data.
package ext_io_pkg;

  // Clock and pulse timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned TRIG_MIN_NS   = 2_000;
  localparam int unsigned TRIG_CYCLES   =
    (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned TRIG_CNT_W    = 8;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] EVENT_ADDR  = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_LOAD_BIT   = 0;
  localparam int unsigned CTRL_SHORT_BIT  = 1;
  localparam int unsigned CTRL_SEQTRG_BIT = 2;
  localparam int unsigned CTRL_SRC_LSB    = 4;
  localparam int unsigned CTRL_RANGE_LSB  = 8;

  // Status register fields
  localparam int unsigned ST_RANGE_LSB  = 0;
  localparam int unsigned ST_ALARM_BIT  = 2;
  localparam int unsigned ST_MSG_BIT    = 3;
  localparam int unsigned ST_SHORT_BIT  = 4;
  localparam int unsigned ST_LOAD_BIT   = 5;
  localparam int unsigned ST_TRIG_BIT   = 6;
  localparam int unsigned ST_SCALE_BIT  = 7;
  localparam int unsigned ST_EXTOK_BIT  = 8;

  // Event register fields (write one to act)
  localparam int unsigned EV_DYN_BIT    = 0;
  localparam int unsigned EV_SEQ_BIT    = 1;
  localparam int unsigned EV_MSGCLR_BIT = 2;

  // Current range encoding
  typedef enum logic [1:0] {
    RANGE_HIGH = 2'h0,
    RANGE_MID  = 2'h1,
    RANGE_LOW  = 2'h2
  } range_type;

  // External control source setting
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_V   = 3'h1,
    SRC_R   = 3'h2,
    SRC_RIV = 3'h3
  } src_type;

  // Range select pin pairs (bit1, bit0)
  localparam logic [1:0] SEL_HIGH = 2'h3;
  localparam logic [1:0] SEL_MID  = 2'h2;
  localparam logic [1:0] SEL_LOW  = 2'h1;

  // Range status pin pairs (bit1, bit0)
  localparam logic [1:0] RST_HIGH = 2'h0;
  localparam logic [1:0] RST_MID  = 2'h1;
  localparam logic [1:0] RST_LOW  = 2'h2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// [ext_switches.sv]
// Model of the outside switches wired to the control connector pins.
// Assumes pull-ups on every pin, so a released switch reads high.
`timescale 1ns/1ps
module ext_switches (
  input  wire logic sel_close1,
  input  wire logic sel_close0,
  input  wire logic alarm_close,
  output logic      range_sel1,
  output logic      range_sel0,
  output logic      alarm_in_n
);
  // Closed switch pulls to common; an open one leaves the pull-up high
  assign range_sel1 = sel_close1 ? 1'b0 : 1'b1;
  assign range_sel0 = sel_close0 ? 1'b0 : 1'b1;
  // Low raises the alarm, release clears it
  assign alarm_in_n = alarm_close ? 1'b0 : 1'b1;
endmodule

// [load_external_control_io_test.sv]
// Self-checking bench for the external control connector block.
// Assumes the switch model drives the pins and APB reaches the registers.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module load_external_control_io_test;
  import ext_io_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, err;
  logic        range_sel1, range_sel0, alarm_in_n;
  logic        load_on_status, range_status1, range_status0;
  logic        short_contact, trigger_pulse_output;
  logic        current_monitor_output, alarm_active, external_alarm_message;
  logic [1:0]  sel_close;
  logic        alarm_close;
  int          num_errors, total_checks, cnt;
  logic [1:0]  sels [4] = '{SEL_HIGH, SEL_MID, SEL_LOW, 2'h0};
  logic [1:0]  exps [4] = '{RST_HIGH, RST_MID, RST_LOW, RST_LOW};
  src_type     srcs [3] = '{SRC_V, SRC_R, SRC_RIV};

  ext_io #(.TRIG_LEN(TRIG_CYCLES)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .range_sel1(range_sel1), .range_sel0(range_sel0),
    .alarm_in_n(alarm_in_n), .load_on_status(load_on_status),
    .range_status1(range_status1), .range_status0(range_status0),
    .short_contact(short_contact),
    .trigger_pulse_output(trigger_pulse_output),
    .current_monitor_output(current_monitor_output),
    .alarm_active(alarm_active),
    .external_alarm_message(external_alarm_message));
  ext_switches sw_u (.sel_close1(sel_close[1]), .sel_close0(sel_close[0]),
    .alarm_close(alarm_close), .range_sel1(range_sel1),
    .range_sel0(range_sel0), .alarm_in_n(alarm_in_n));

  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // One APB transfer; waits for pready, never assumes its latency
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl(logic ld, logic sh, logic sq,
                                       logic [2:0] src, logic [1:0] rng);
    return {22'h0, rng, 1'b0, src, 1'b0, sq, sh, ld};
  endfunction

  task automatic settle(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Range pair and monitor scale: small scale only in the middle range
  task automatic chk_range(logic [1:0] st);
    `CHK({range_status1, range_status0}, st)
    `CHK(current_monitor_output, (st !== RST_MID))
  endtask

  // Count trigger high cycles, starting in the cycle the write lands
  task automatic count_trig();
    cnt = 0;
    repeat (80) begin
      #1;
      if (trigger_pulse_output === 1'b1) cnt++;
      @(posedge pclk);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    sel_close = 2'h0; alarm_close = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    chk_range(RST_HIGH);
    // Load and short follow the control bits, both ways
    apb(1'b1, CTRL_ADDR, ctrl(1, 1, 0, SRC_OFF, RANGE_HIGH));
    settle(2);
    `CHK(load_on_status, 1'b1)
    `CHK(short_contact, 1'b1)
    apb(1'b0, CTRL_ADDR, 32'h0000_0000);
    `CHK(q, ctrl(1, 1, 0, SRC_OFF, RANGE_HIGH))
    apb(1'b0, STATUS_ADDR, 32'h0000_0000);
    `CHK(q[ST_LOAD_BIT], 1'b1)
    `CHK(q[ST_SHORT_BIT], 1'b1)
    apb(1'b1, CTRL_ADDR, ctrl(0, 0, 0, SRC_OFF, RANGE_HIGH));
    settle(2);
    `CHK(load_on_status, 1'b0)
    `CHK(short_contact, 1'b0)
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK(err, 1'b1)
    $display("test load_short done");
    // Manual ranges with pins ignored
    apb(1'b1, CTRL_ADDR, ctrl(0, 0, 0, SRC_OFF, RANGE_MID));
    settle(3);
    chk_range(RST_MID);
    sel_close <= ~SEL_MID;
    apb(1'b1, CTRL_ADDR, ctrl(0, 0, 0, SRC_OFF, RANGE_HIGH));
    settle(10);
    chk_range(RST_HIGH);
    // Every accepted source follows the pins
    foreach (srcs[s]) begin
      sel_close <= ~SEL_HIGH;
      apb(1'b1, CTRL_ADDR, ctrl(0, 0, 0, srcs[s], RANGE_HIGH));
      settle(10);
      sel_close <= ~SEL_MID;
      settle(10);
      chk_range(RST_MID);
    end
    // Pin table, ending with both low which holds the range
    foreach (sels[i]) begin
      sel_close <= ~sels[i];
      settle(10);
      chk_range(exps[i]);
    end
    // Manual low blocks external selection
    apb(1'b1, CTRL_ADDR, ctrl(0, 0, 0, SRC_V, RANGE_LOW));
    sel_close <= ~SEL_MID;
    settle(10);
    chk_range(RST_LOW);
    $display("test range done");
    // Alarm pin low raises alarm and message; message stays until cleared
    alarm_close <= 1'b1;
    settle(10);
    `CHK(alarm_active, 1'b1)
    `CHK(external_alarm_message, 1'b1)
    apb(1'b0, STATUS_ADDR, 32'h0000_0000);
    `CHK(q[ST_ALARM_BIT], 1'b1)
    `CHK(q[ST_MSG_BIT], 1'b1)
    alarm_close <= 1'b0;
    settle(10);
    `CHK(alarm_active, 1'b0)
    `CHK(external_alarm_message, 1'b1)
    apb(1'b1, EVENT_ADDR, 32'h0000_0004);
    settle(2);
    `CHK(external_alarm_message, 1'b0)
    $display("test alarm done");
    // Dynamic switch pulses once for the full width
    apb(1'b1, EVENT_ADDR, 32'h0000_0001);
    count_trig();
    `CHK(cnt, TRIG_CYCLES)
    apb(1'b1, EVENT_ADDR, 32'h0000_0002);
    count_trig();
    `CHK(cnt, 0)
    apb(1'b1, CTRL_ADDR, ctrl(0, 0, 1, SRC_OFF, RANGE_HIGH));
    apb(1'b1, EVENT_ADDR, 32'h0000_0002);
    count_trig();
    `CHK(cnt, TRIG_CYCLES)
    $display("test trigger done");
    complete_run();
  end
endmodule

// [pin_sync.sv]
// Three-stage pin synchroniser; output moves when stages two and three agree.
// Assumes an asynchronous pin, idle high (pulled up), and one pclk domain.
`timescale 1ns/1ps
module pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_type;

  sync_state_type st_q;
  sync_state_type st_d;

  // Stage one feeds stage two only; agreement filters single-cycle glitches
  always_comb begin
    st_d     = st_q;
    st_d.s1  = pin;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // Reset to the pulled-up idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 4'hF;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
endmodule
